// file: rtl/amu_pkg.sv
// Shared constants and carrier types for the alarm monitor unit
package amu_pkg;

	// Serial frame layout
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned AXES       = 3;

	// Register byte addresses on the serial port
	localparam logic [6:0] ADDR_FLASH_WRITE_COUNTER = 7'h00;
	localparam logic [6:0] ADDR_LEVEL_X   = 7'h20;
	localparam logic [6:0] ADDR_LEVEL_Y   = 7'h22;
	localparam logic [6:0] ADDR_LEVEL_Z   = 7'h24;
	localparam logic [6:0] ADDR_LEVEL_S   = 7'h26;
	localparam logic [6:0] ADDR_WINDOW_X  = 7'h28;
	localparam logic [6:0] ADDR_WINDOW_Y  = 7'h2a;
	localparam logic [6:0] ADDR_WINDOW_Z  = 7'h2c;
	localparam logic [6:0] ADDR_ALM_CFG   = 7'h2e;
	localparam logic [6:0] ADDR_DIO_FN    = 7'h36;
	localparam logic [6:0] ADDR_DIAG      = 7'h3c;
	localparam logic [6:0] ADDR_GCMD      = 7'h3e;

	// Reset values
	localparam logic [15:0] LEVEL_RST  = 16'h0000;
	localparam logic [7:0]  WINDOW_RST = 8'h01;
	localparam logic [15:0] CFG_RST    = 16'h0000;
	localparam logic [5:0]  DIO_RST    = 6'h07;
	localparam logic [15:0] CNT_RST    = 16'h0000;

	// Alarm configuration field positions
	localparam int unsigned CFG_EN_LSB  = 0;
	localparam int unsigned CFG_SRC_LSB = 4;
	localparam int unsigned CFG_SYS_SRC = 7;
	localparam int unsigned CFG_POL_LSB = 8;
	localparam int unsigned CFG_DYN_LSB = 12;
	localparam logic [15:0] CFG_MASK    = 16'h7fff;

	// Diagnostic flag positions
	localparam int unsigned DIAG_FLASH   = 6;
	localparam int unsigned DIAG_ALM_LSB = 8;

	// Global command bits
	localparam int unsigned GCMD_CLEAR = 4;
	localparam int unsigned GCMD_FLASH = 5;

	// Digital line function field positions and codes
	localparam int unsigned DIO_POL_LSB = 0;
	localparam int unsigned DIO_FN1_LSB = 2;
	localparam int unsigned DIO_FN2_LSB = 4;
	localparam logic [1:0]  FN_GPIO     = 2'h0;
	localparam logic [1:0]  FN_DRDY     = 2'h1;
	localparam logic [1:0]  FN_ALARM    = 2'h2;
	localparam logic [1:0]  FN_BUSY     = 2'h3;

	// One set of freshly updated output words
	typedef struct packed {
		logic [15:0] accel_x_word;
		logic [15:0] accel_y_word;
		logic [15:0] accel_z_word;
		logic [15:0] incline_x_word;
		logic [15:0] incline_y_word;
		logic [15:0] incline_z_word;
		logic [15:0] supply_word;
		logic [15:0] temp_word;
	} amu_samples_s;

	// One received serial frame
	typedef struct packed {
		logic       write;
		logic [6:0] addr;
		logic [7:0] data;
	} amu_frame_s;

endpackage : amu_pkg

// file: rtl/amu_spi_port.sv
// Serial register port: frame receiver and read-word shifter
`timescale 1ns/100ps
module amu_spi_port
	import amu_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	input  wire logic [15:0] rd_word,
	output logic             dout,
	output amu_frame_s       frame,
	output logic             frame_vld
);

	logic        sclk_r;
	logic [3:0]  cnt_r;
	logic [15:0] rx_r;
	logic [15:0] tx_r;
	wire         rise_w = sclk & ~sclk_r;
	wire         fall_w = ~sclk & sclk_r;
	wire  [15:0] rx_nxt = {rx_r[14:0], din};

	// Sample on rising clock, shift out on falling; read answer
	// travels in the frame after the one that asked for it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sclk_r    <= 1'b1;
			cnt_r     <= 4'h0;
			rx_r      <= 16'h0000;
			tx_r      <= 16'h0000;
			dout      <= 1'b0;
			frame     <= '0;
			frame_vld <= 1'b0;
		end
		else
		begin
			sclk_r    <= sclk;
			frame_vld <= 1'b0;
			if (cs_n)
				cnt_r <= 4'h0;
			else if (rise_w)
			begin
				rx_r  <= rx_nxt;
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == 4'hf)
				begin
					frame     <= rx_nxt;
					frame_vld <= 1'b1;
				end
			end
			if (fall_w && !cs_n)
			begin
				dout <= tx_r[15];
				tx_r <= {tx_r[14:0], 1'b0};
			end
			// Load wins over a shift in the same cycle
			if (frame_vld && !frame.write)
				tx_r <= rd_word;
		end
	end

endmodule : amu_spi_port

// file: rtl/amu_alarm_monitor.sv
// Alarm monitor unit: alarm registers, comparators, flags, digital lines
//
// Behaviour
// RL1 - Four independent alarms with own level, polarity
// RL2 - Config bits 3:0 enable X,Y,Z,system alarms
// RL3 - Bits 6:4 pick inclination or acceleration source
// RL4 - Bit 7 picks supply or temperature word
// RL5 - Bits 11:8 pick above or below trigger
// RL6 - Bits 14:12 dynamic mode; bit 15 unused
// RL7 - Static mode compares source against level directly
// RL8 - Dynamic mode: change over N samples exceeds level
// RL9 - Window registers: 8-bit count, reset to one
// RL10 - Window sample spacing equals output sample period
// RL11 - Levels use source format, reset to zero
// RL12 - Alarm sets diagnostic flag bits 11:8
// RL13 - Either digital line can show alarm indicator
// RL14 - Command bit 5 starts flash test; flag bit 6
// RL15 - Read-only running flash write cycle count
// RL16 - Command bit 4 clears flags and indicator
// RL17 - Line function codes: gpio, ready, alarm, busy
// RL18 - Flags: one means error, sticky until cleared
// RL19 - Host writes 16-bit words as two bytes
// RL20 - Alarms evaluated once per output sample update
`timescale 1ns/100ps
module amu_alarm_monitor
	import amu_pkg::*;
#(
	parameter int unsigned HIST_DEPTH = 256
)
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	input  wire logic        sample_valid,
	input  amu_samples_s     samples,
	input  wire logic        data_ready_in,
	input  wire logic        busy_in,
	input  wire logic [1:0]  gpio_level,
	input  wire logic [1:0]  gpio_dir,
	input  wire logic [1:0]  dio_in,
	input  wire logic        flash_write_pulse,
	input  wire logic        flash_test_done,
	input  wire logic        flash_test_pass,
	output logic             flash_test_start,
	output logic [1:0]       dio_o,
	output logic [1:0]       dio_oe
);

	// Window count is 8 bits, so the history must hold 256 words
	if (HIST_DEPTH != 256)
	begin : g_depth_check
		$error("HIST_DEPTH must be 256");
	end

	amu_frame_s  frame;
	logic        frame_vld;
	logic [15:0] rd_word;

	logic [15:0] level_r [4];
	logic [7:0]  win_r [AXES];
	logic [15:0] cfg_r;
	logic [5:0]  dio_fn_r;
	logic [15:0] flash_write_counter_r;
	logic [3:0]  alm_flag_r;
	logic        flash_fail_r;
	logic [15:0] hist_r [AXES][HIST_DEPTH];
	logic [7:0]  wr_ptr_r;
	logic [7:0]  fill_r;

	// Serial port front end
	amu_spi_port u_port (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sclk      (sclk),
		.cs_n      (cs_n),
		.din       (din),
		.rd_word   (rd_word),
		.dout      (dout),
		.frame     (frame),
		.frame_vld (frame_vld)
	);

	// Merge one byte into a word; odd address holds upper byte
	function automatic logic [15:0] wr_byte(
		input logic [15:0] old,
		input logic        hi,
		input logic [7:0]  data
	);
		wr_byte = hi ? {data, old[7:0]} : {old[15:8], data}; // RL19
	endfunction : wr_byte

	// Static compare in the chosen direction
	function automatic logic lvl_hit(
		input logic        above,
		input logic        signed_fmt,
		input logic [15:0] src,
		input logic [15:0] lvl
	);
		logic gt;
		logic lt;
		gt = signed_fmt ? ($signed(src) > $signed(lvl)) : (src > lvl);
		lt = signed_fmt ? ($signed(src) < $signed(lvl)) : (src < lvl);
		lvl_hit = above ? gt : lt; // RL5
	endfunction : lvl_hit

	// Rate compare: signed change against signed level
	function automatic logic dyn_hit(
		input logic        above,
		input logic [15:0] now_w,
		input logic [15:0] old_w,
		input logic [15:0] lvl
	);
		logic signed [16:0] diff;
		logic signed [16:0] mag;
		diff = $signed({now_w[15], now_w}) - $signed({old_w[15], old_w});
		mag  = $signed({lvl[15], lvl});
		dyn_hit = above ? (diff > mag) : (diff < mag); // RL8
	endfunction : dyn_hit

	// Read decode over word addresses; unmapped words read zero
	function automatic logic [15:0] rd_decode(input logic [6:0] a);
		unique case ({a[6:1], 1'b0})
			ADDR_FLASH_WRITE_COUNTER: rd_decode = flash_write_counter_r; // RL15
			ADDR_LEVEL_X:   rd_decode = level_r[0];
			ADDR_LEVEL_Y:   rd_decode = level_r[1];
			ADDR_LEVEL_Z:   rd_decode = level_r[2];
			ADDR_LEVEL_S:   rd_decode = level_r[3];
			ADDR_WINDOW_X:  rd_decode = {8'h00, win_r[0]}; // RL9
			ADDR_WINDOW_Y:  rd_decode = {8'h00, win_r[1]};
			ADDR_WINDOW_Z:  rd_decode = {8'h00, win_r[2]};
			ADDR_ALM_CFG:   rd_decode = cfg_r;
			ADDR_DIO_FN:    rd_decode = {10'h000, dio_fn_r};
			ADDR_DIAG:      rd_decode = {4'h0, alm_flag_r, 1'b0,
				flash_fail_r, 6'h00}; // RL12
			default:        rd_decode = 16'h0000;
		endcase
	endfunction : rd_decode

	// Process form so the word follows register changes, not only the address
	always_comb
	begin
		rd_word = rd_decode(frame.addr);
	end

	// Write strobes
	wire        wr_w     = frame_vld & frame.write;
	wire [6:0]  wr_word  = {frame.addr[6:1], 1'b0};
	wire        wr_hi    = frame.addr[0];
	wire        gcmd_w   = wr_w & (frame.addr == ADDR_GCMD);
	wire        clr_w    = gcmd_w & frame.data[GCMD_CLEAR]; // RL16
	wire        fstart_w = gcmd_w & frame.data[GCMD_FLASH]; // RL14

	// Source selection per alarm
	wire [15:0] accel_w [AXES];
	wire [15:0] incl_w [AXES];
	wire [15:0] src_w [AXES];
	assign accel_w[0] = samples.accel_x_word;
	assign accel_w[1] = samples.accel_y_word;
	assign accel_w[2] = samples.accel_z_word;
	assign incl_w[0]  = samples.incline_x_word;
	assign incl_w[1]  = samples.incline_y_word;
	assign incl_w[2]  = samples.incline_z_word;
	wire [15:0] sys_src_w = cfg_r[CFG_SYS_SRC] ?
		samples.supply_word : samples.temp_word; // RL4

	// Per-axis hit logic, static or dynamic
	logic [3:0] hit_w;
	wire  [15:0] old_w [AXES];
	wire         rdy_w [AXES];
	for (genvar i = 0; i < AXES; i++)
	begin : g_axis
		wire [7:0] rd_idx = wr_ptr_r - win_r[i];
		assign src_w[i] = cfg_r[CFG_SRC_LSB + i] ?
			incl_w[i] : accel_w[i]; // RL3
		assign old_w[i] = hist_r[i][rd_idx];
		// A window of zero never fires; history must cover the window
		assign rdy_w[i] = (win_r[i] != 8'h00) && (fill_r >= win_r[i]);
		wire static_hit = lvl_hit(cfg_r[CFG_POL_LSB + i], 1'b1,
			src_w[i], level_r[i]); // RL7 RL11
		wire dynamic_hit = rdy_w[i] && dyn_hit(cfg_r[CFG_POL_LSB + i],
			src_w[i], old_w[i], level_r[i]); // RL8
		assign hit_w[i] = sample_valid & cfg_r[CFG_EN_LSB + i] &
			(cfg_r[CFG_DYN_LSB + i] ? dynamic_hit : static_hit); // RL1 RL2 RL6
	end

	// System alarm has no dynamic option; unsigned compare
	assign hit_w[3] = sample_valid & cfg_r[CFG_EN_LSB + 3] &
		lvl_hit(cfg_r[CFG_POL_LSB + 3], 1'b0,
			sys_src_w, level_r[3]); // RL1 RL2 RL6

	// Sticky flags; a hit in the clearing cycle survives
	wire [3:0] alm_flag_nxt = hit_w | (alm_flag_r & {4{~clr_w}}); // RL12 RL18
	wire       flash_fail_nxt = (flash_test_done & ~flash_test_pass) |
		(flash_fail_r & ~clr_w); // RL14 RL18

	// Control registers written byte by byte
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < 4; k++)
				level_r[k] <= LEVEL_RST; // RL11
			for (int k = 0; k < AXES; k++)
				win_r[k] <= WINDOW_RST; // RL9
			cfg_r    <= CFG_RST;
			dio_fn_r <= DIO_RST;
		end
		else if (wr_w)
		begin
			for (int k = 0; k < 4; k++)
				if (wr_word == ADDR_LEVEL_X + 7'(2 * k))
					level_r[k] <= wr_byte(level_r[k], wr_hi, frame.data);
			// Upper byte of window registers is not stored
			for (int k = 0; k < AXES; k++)
				if (frame.addr == ADDR_WINDOW_X + 7'(2 * k))
					win_r[k] <= frame.data; // RL9
			if (wr_word == ADDR_ALM_CFG)
				cfg_r <= wr_byte(cfg_r, wr_hi, frame.data) & CFG_MASK; // RL6
			if (frame.addr == ADDR_DIO_FN)
				dio_fn_r <= frame.data[5:0];
		end
	end

	// Flags, flash counter and test start strobe
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			alm_flag_r       <= 4'h0;
			flash_fail_r     <= 1'b0;
			flash_write_counter_r      <= CNT_RST;
			flash_test_start <= 1'b0;
		end
		else
		begin
			alm_flag_r       <= alm_flag_nxt;
			flash_fail_r     <= flash_fail_nxt;
			flash_test_start <= fstart_w; // RL14
			if (flash_write_pulse)
				flash_write_counter_r <= flash_write_counter_r + 16'h0001; // RL15
		end
	end

	// Sample history for rate compare, one entry per output update;
	// memory is left without reset, validity tracked by fill_r
	always_ff @(posedge mclk)
	begin
		if (sample_valid)
			for (int k = 0; k < AXES; k++)
				hist_r[k][wr_ptr_r] <= src_w[k]; // RL10 RL20
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= 8'h00;
			fill_r   <= 8'h00;
		end
		else if (sample_valid)
		begin
			wr_ptr_r <= wr_ptr_r + 8'h01; // RL10
			if (fill_r != 8'hff)
				fill_r <= fill_r + 8'h01;
		end
	end

	// Digital lines: function select then polarity
	wire       alarm_ind = |alm_flag_r; // RL13
	wire [1:0] fn_w [2];
	wire [1:0] line_val;
	wire [1:0] line_oe;
	assign fn_w[0] = dio_fn_r[DIO_FN1_LSB +: 2];
	assign fn_w[1] = dio_fn_r[DIO_FN2_LSB +: 2];
	for (genvar j = 0; j < 2; j++)
	begin : g_line
		wire raw = (fn_w[j] == FN_ALARM) ? alarm_ind :
			(fn_w[j] == FN_DRDY) ? data_ready_in : busy_in; // RL17
		wire pol = dio_fn_r[DIO_POL_LSB + j];
		assign line_val[j] = (fn_w[j] == FN_GPIO) ? gpio_level[j] :
			(pol ? raw : ~raw); // RL13 RL17
		assign line_oe[j] = (fn_w[j] == FN_GPIO) ? gpio_dir[j] : 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			dio_o  <= 2'b00;
			dio_oe <= 2'b00;
		end
		else
		begin
			dio_o  <= line_val; // RL16
			dio_oe <= line_oe;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_disabled_quiet;
		!cfg_r[CFG_EN_LSB] && !alm_flag_r[0] |=> !alm_flag_r[0];
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) // RL2
		else $error("disabled X alarm raised its flag");

	property p_static_above;
		sample_valid && cfg_r[CFG_EN_LSB] && !cfg_r[CFG_DYN_LSB] &&
		cfg_r[CFG_POL_LSB] && ($signed(src_w[0]) > $signed(level_r[0]))
		|=> alm_flag_r[0];
	endproperty
	a_static_above: assert property (p_static_above) // RL7
		else $error("static X alarm missed");

	property p_sys_below;
		sample_valid && cfg_r[CFG_EN_LSB + 3] && !cfg_r[CFG_POL_LSB + 3]
		&& (sys_src_w < level_r[3]) |=> alm_flag_r[3];
	endproperty
	a_sys_below: assert property (p_sys_below) // RL12
		else $error("system alarm flag not set");

	property p_dynamic_x;
		sample_valid && cfg_r[CFG_EN_LSB] && cfg_r[CFG_DYN_LSB]
		&& rdy_w[0] && dyn_hit(cfg_r[CFG_POL_LSB], src_w[0],
		old_w[0], level_r[0]) |=> alm_flag_r[0];
	endproperty
	a_dynamic_x: assert property (p_dynamic_x) // RL8
		else $error("dynamic X alarm missed");

	property p_sticky;
		alm_flag_r[1] && !clr_w |=> alm_flag_r[1];
	endproperty
	a_sticky: assert property (p_sticky) // RL18
		else $error("alarm flag dropped without clear");

	sequence s_clear_cmd;
		clr_w && !sample_valid && !flash_test_done;
	endsequence
	sequence s_all_clear;
		(alm_flag_r == 4'h0) && !flash_fail_r;
	endsequence
	property p_clear;
		s_clear_cmd |=> s_all_clear;
	endproperty
	a_clear: assert property (p_clear) // RL16
		else $error("clear command left a flag set");

	sequence s_ind_line2;
		fn_w[1] == FN_ALARM && dio_fn_r[DIO_POL_LSB + 1] && !frame_vld;
	endsequence
	property p_indicator;
		(alm_flag_r != 4'h0) and s_ind_line2 |=> dio_o[1] && dio_oe[1];
	endproperty
	a_indicator: assert property (p_indicator) // RL13
		else $error("alarm indicator not driven active");

	sequence s_flash_cmd;
		fstart_w;
	endsequence
	property p_flash_start;
		s_flash_cmd |=> flash_test_start ##1 !flash_test_start;
	endproperty
	a_flash_start: assert property (p_flash_start) // RL14
		else $error("flash test start strobe wrong");

	property p_flash_count;
		flash_write_pulse |=> flash_write_counter_r == $past(flash_write_counter_r) + 16'h0001;
	endproperty
	a_flash_count: assert property (p_flash_count) // RL15
		else $error("flash write counter did not advance");

	property p_reset_values;
		$rose(rst_n) |-> win_r[0] == WINDOW_RST && level_r[2] == LEVEL_RST;
	endproperty
	a_reset_values: assert property (p_reset_values) // RL9
		else $error("window or level reset value wrong");

endmodule : amu_alarm_monitor

// file: verif/amu_host_model.sv
// Host processor model driving the serial register port
`timescale 1ns/100ps
module amu_host_model
	import amu_pkg::*;
(
	input  wire logic mclk,
	input  wire logic dout,
	output logic      sclk,
	output logic      cs_n,
	output logic      din
);
	// Idle: deselected, serial clock parked high
	initial
	begin
		sclk = 1'h1;
		cs_n = 1'h1;
		din  = 1'h0;
	end

	// One frame, MSB first; half period of 5 mclk keeps the sampler happy
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(negedge mclk);
		cs_n = 1'h0;
		for (int i = 15; i >= 0; i--)
		begin
			repeat (5) @(negedge mclk);
			sclk = 1'h0;
			din  = tx[i];
			repeat (5) @(negedge mclk);
			sclk = 1'h1;
			rx[i] = dout;
		end
		repeat (5) @(negedge mclk);
		cs_n = 1'h1;
		// Released line must not look like held data
		din = ~din;
	endtask : xfer

	// Single byte write; each byte lands on its own
	task automatic wr8(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] rx;
		xfer({1'h1, a, d}, rx);
	endtask : wr8

	// Word write: upper byte to odd address, lower byte to even
	task automatic wr16(input logic [6:0] a, input logic [15:0] v);
		wr8(a | 7'h01, v[15:8]);
		wr8(a & 7'h7e, v[7:0]);
	endtask : wr16

	// Word read: the answer only comes out during the next frame
	task automatic rd16(input logic [6:0] a, output logic [15:0] v);
		logic [15:0] rx;
		xfer({1'h0, a, 8'h00}, rx);
		xfer(16'h0000, v);
	endtask : rd16
endmodule : amu_host_model

// file: verif/test_alarm_monitor_unit.sv
// Self-checking bench for the alarm monitor unit
`timescale 1ns/100ps
module test_alarm_monitor_unit
	import amu_pkg::*;
;
	logic         mclk, rst_n, sclk, cs_n, din, dout;
	logic         sample_valid, data_ready_in, busy_in;
	logic [15:0]  w [8];
	amu_samples_s samples;
	logic [1:0]   gpio_level, gpio_dir, dio_o, dio_oe;
	logic         flash_write_pulse, flash_test_done, flash_test_pass;
	logic         flash_test_start;
	int           err_count, n_tests, cycles, n_start;

	// Sample words in struct order: accel xyz, incline xyz, supply, temp
	assign samples = {w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};

	amu_alarm_monitor #(.HIST_DEPTH(256)) amu_alarm_monitor_inst (
		.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .sample_valid(sample_valid), .samples(samples),
		.data_ready_in(data_ready_in), .busy_in(busy_in),
		.gpio_level(gpio_level), .gpio_dir(gpio_dir), .dio_in(dio_o),
		.flash_write_pulse(flash_write_pulse),
		.flash_test_done(flash_test_done), .flash_test_pass(flash_test_pass),
		.flash_test_start(flash_test_start), .dio_o(dio_o), .dio_oe(dio_oe)
	);

	amu_host_model amu_host_model_inst (
		.mclk(mclk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din)
	);

	// 40 MHz clock
	initial
	begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// Hang guard, well above the expected run length
	always @(posedge mclk)
	begin
		cycles++;
		if (flash_test_start === 1'h1)
			n_start++;
		if (cycles == 60000)
		begin
			err_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_reg(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] v;
		amu_host_model_inst.rd16(a, v);
		chk(v, exp);
	endtask : chk_reg

	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		amu_host_model_inst.wr16(a, v);
	endtask : wr

	task automatic clear();
		amu_host_model_inst.wr8(ADDR_GCMD, 8'h10);
	endtask : clear

	// One sample update, then let flag and line registers settle
	task automatic smp();
		@(negedge mclk);
		sample_valid = 1'h1;
		@(negedge mclk);
		sample_valid = 1'h0;
		repeat (3) @(negedge mclk);
	endtask : smp

	task automatic t_reset();
		for (int i = 0; i < 4; i++)
			chk_reg(ADDR_LEVEL_X + 7'(2 * i), 16'h0000);
		for (int i = 0; i < 3; i++)
			chk_reg(ADDR_WINDOW_X + 7'(2 * i), 16'h0001);
		chk_reg(ADDR_ALM_CFG, 16'h0000);
		chk_reg(ADDR_DIAG, 16'h0000);
		chk_reg(ADDR_FLASH_WRITE_COUNTER, 16'h0000);
		chk_reg(7'h10, 16'h0000);
		$display("reset values done");
	endtask : t_reset

	task automatic t_regs();
		wr(ADDR_ALM_CFG, 16'hffff);
		chk_reg(ADDR_ALM_CFG, 16'h7fff);
		wr(ADDR_WINDOW_Y, 16'h1234);
		chk_reg(ADDR_WINDOW_Y, 16'h0034);
		wr(ADDR_LEVEL_S, 16'ha5c3);
		chk_reg(ADDR_LEVEL_S, 16'ha5c3);
		wr(ADDR_FLASH_WRITE_COUNTER, 16'hffff);
		chk_reg(ADDR_FLASH_WRITE_COUNTER, 16'h0000);
		wr(ADDR_ALM_CFG, 16'h0000);
		$display("register access done");
	endtask : t_regs

	// Disabled, wrong source, hit, sticky, clear, then below-level trigger
	task automatic t_static(input int i);
		logic [15:0] en, src, pol, flag;
		int          sel, oth;
		en   = 16'h0001 << i;
		src  = 16'h0010 << i;
		pol  = 16'h0100 << i;
		flag = 16'h0100 << i;
		sel  = (i < 3) ? 3 + i : 6;
		oth  = (i < 3) ? i : 7;
		foreach (w[k]) w[k] = 16'h0000;
		clear();
		wr(ADDR_LEVEL_X + 7'(2 * i), 16'h0100);
		wr(ADDR_ALM_CFG, src | pol);
		w[sel] = 16'h0200;
		smp();
		chk_reg(ADDR_DIAG, 16'h0000);
		wr(ADDR_ALM_CFG, en | src | pol);
		w[sel] = 16'h0000;
		w[oth] = 16'h0200;
		smp();
		chk_reg(ADDR_DIAG, 16'h0000);
		w[sel] = 16'h0200;
		smp();
		chk_reg(ADDR_DIAG, flag);
		w[sel] = 16'h0000;
		smp();
		chk_reg(ADDR_DIAG, flag);
		clear();
		chk_reg(ADDR_DIAG, 16'h0000);
		wr(ADDR_ALM_CFG, en | src);
		w[sel] = 16'h0050;
		smp();
		chk_reg(ADDR_DIAG, flag);
		// Source bit clear: acceleration or temperature word is watched
		clear();
		wr(ADDR_ALM_CFG, en);
		smp();
		chk_reg(ADDR_DIAG, 16'h0000);
		w[oth] = 16'h0050;
		smp();
		chk_reg(ADDR_DIAG, flag);
		$display("static alarm %0d done", i);
	endtask : t_static

	// Large values but small change must stay quiet over a 2-sample window
	task automatic t_dynamic();
		foreach (w[k]) w[k] = 16'h0000;
		clear();
		wr(ADDR_WINDOW_X, 16'h0002);
		wr(ADDR_LEVEL_X, 16'h0064);
		wr(ADDR_ALM_CFG, 16'h1101);
		w[0] = 16'h0200;
		smp();
		smp();
		// Jump from the idle history fires
		chk_reg(ADDR_DIAG, 16'h0100);
		clear();
		w[0] = 16'h0240;
		smp();
		chk_reg(ADDR_DIAG, 16'h0000);
		w[0] = 16'h0290;
		smp();
		chk_reg(ADDR_DIAG, 16'h0100);
		$display("dynamic alarm done");
	endtask : t_dynamic

	// Line codes: ready and alarm, busy, general purpose
	task automatic t_dio();
		foreach (w[k]) w[k] = 16'h0000;
		clear();
		wr(ADDR_LEVEL_X, 16'h0100);
		wr(ADDR_ALM_CFG, 16'h0101);
		amu_host_model_inst.wr8(ADDR_DIO_FN, 8'h27);
		data_ready_in = 1'h1;
		repeat (3) @(negedge mclk);
		chk({12'h000, dio_oe, dio_o}, 16'h000d);
		data_ready_in = 1'h0;
		w[0] = 16'h0200;
		smp();
		chk({12'h000, dio_oe, dio_o}, 16'h000e);
		clear();
		chk({12'h000, dio_oe, dio_o}, 16'h000c);
		amu_host_model_inst.wr8(ADDR_DIO_FN, 8'h3f);
		busy_in = 1'h1;
		repeat (3) @(negedge mclk);
		chk({12'h000, dio_oe, dio_o}, 16'h000f);
		amu_host_model_inst.wr8(ADDR_DIO_FN, 8'h3c);
		chk({12'h000, dio_oe, dio_o}, 16'h000c);
		busy_in = 1'h0;
		gpio_dir = 2'h1;
		gpio_level = 2'h1;
		amu_host_model_inst.wr8(ADDR_DIO_FN, 8'h03);
		chk({13'h0000, dio_oe, dio_o[0]}, 16'h0003);
		$display("digital lines done");
	endtask : t_dio

	task automatic t_flash();
		n_start = 0;
		amu_host_model_inst.wr8(ADDR_GCMD, 8'h20);
		chk(16'(n_start), 16'h0001);
		@(negedge mclk);
		flash_test_done = 1'h1;
		@(negedge mclk);
		flash_test_done = 1'h0;
		chk_reg(ADDR_DIAG, 16'h0040);
		flash_test_pass = 1'h1;
		flash_test_done = 1'h1;
		@(negedge mclk);
		flash_test_done = 1'h0;
		chk_reg(ADDR_DIAG, 16'h0040);
		clear();
		chk_reg(ADDR_DIAG, 16'h0000);
		for (int k = 0; k < 3; k++)
		begin
			@(negedge mclk);
			flash_write_pulse = 1'h1;
			@(negedge mclk);
			flash_write_pulse = 1'h0;
		end
		chk_reg(ADDR_FLASH_WRITE_COUNTER, 16'h0003);
		$display("flash checks done");
	endtask : t_flash

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// Main sequence
	initial
	begin
		rst_n = 1'h0;
		sample_valid = 1'h0;
		foreach (w[k]) w[k] = 16'h0000;
		{data_ready_in, busy_in, gpio_level, gpio_dir} = 6'h00;
		{flash_write_pulse, flash_test_done, flash_test_pass} = 3'h0;
		repeat (4) @(negedge mclk);
		rst_n = 1'h1;
		t_reset();
		t_regs();
		for (int i = 0; i < 4; i++)
			t_static(i);
		t_dynamic();
		t_dio();
		t_flash();
		end_of_test();
	end
endmodule : test_alarm_monitor_unit
